// ==== verilog/gpc_gpio_cfg.v ====
/*
 * sixteen-pin gpio configuration and pin-interrupt block with an apb
 * slave. assumes pins are synchronous-ish inputs sampled on pclk and
 * slow_osc_tick is a one-cycle pulse per slow oscillator period.
 */
// Contract
// - after reset all pin drivers off, pins in high impedance
// - each pin latches rising and falling edges for interrupts
// - pin can serve as interrupt or wakeup via input config
// - sixteen output config registers from A100, reset zero
// - low-side and high-side drive enable bits turn on drivers
// - output invert selects port data or its inverse
// - pull-up and pull-down bits connect resistors
// - sixteen input config registers from A110, reset zero
// - rise flag set on edge, cleared by writing enable zero
// - fall flag set on edge, cleared by writing enable zero
// - input enable bit turns on input buffer, default off
// - interrupts and port reads use debounced input, readable
// - raw status bit returns undebounced buffer output
// - debounce select: off, 4, 16, 64 slow/4 ticks
// - sixteen function select bytes from A120, reset zero
`timescale 1ns/100ps
`include "gpc_defs.vh"

module gpc_gpio_cfg
(
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // timebase
    input  wire        slow_osc_tick,
    // pins
    input  wire [15:0] pin_in,
    output reg  [15:0] pin_out,
    output reg  [15:0] high_side_drive_enable,
    output reg  [15:0] low_side_drive_enable,
    output reg  [15:0] pullup_enable,
    output reg  [15:0] pulldown_enable,
    output reg  [15:0] analog_switch_one,
    output reg  [15:0] analog_switch_two,
    // core side
    input  wire [15:0] port_data,
    output reg  [15:0] port_read,
    output reg  [127:0] function_select,
    output reg         pin_irq_a,
    output reg         pin_irq_b,
    output reg         wakeup
);

    // ****************************************************************
    // register storage
    // ****************************************************************
    reg  [7:0]  ocfg_q [0:15];
    reg  [7:0]  icfg_q [0:15];
    reg  [7:0]  fsel_q [0:15];
    reg  [15:0] rflag_q;
    reg  [15:0] fflag_q;
    reg  [1:0]  div_q;
    reg         slow_tick_q;
    wire [15:0] raw;
    wire [15:0] filt;
    wire [15:0] rise;
    wire [15:0] fall;
    wire        acc;
    wire        aligned;
    wire [15:0] oc_index;
    wire [15:0] ic_index;
    wire [15:0] fs_index;
    reg  [15:0] ev_a;
    reg  [15:0] ev_b;
    // one loop variable per process, so none has two drivers
    integer     i;
    integer     ci;
    integer     oi;

    assign acc      = psel & penable & ~pready;
    // register index n sits at byte address 4*n and paddr carries the
    // low 16 bits of that address: index bits 13:0 are paddr[15:2], the
    // higher index bits are left to the slot decode in front of the block
    assign aligned  = (paddr[1:0] == 2'b00);
    assign oc_index = `GPC_OUT_CFG_BASE;
    assign ic_index = `GPC_IN_CFG_BASE;
    assign fs_index = `GPC_FUNC_SEL_BASE;

    // ****************************************************************
    // slow oscillator divide by four
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_q       <= 2'd0;
            slow_tick_q <= 1'b0;
        end
        else
        begin
            // one slow tick per four oscillator ticks
            slow_tick_q <= 1'b0;
            if (slow_osc_tick)
            begin
                div_q <= div_q + 2'd1;
                if (div_q == `GPC_SLOW_DIV)
                    slow_tick_q <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // per-pin input paths
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : pins
            gpc_pin_filter u_filt
            (
                .pclk                (pclk),
                .presetn             (presetn),
                .pin_in              (pin_in[g]),
                .input_buffer_enable (icfg_q[g][`GPC_IC_INPUT_BUFFER_ENABLE]),
                .input_invert        (icfg_q[g][`GPC_IC_IINV]),
                .debounce_select     (icfg_q[g][`GPC_IC_DBN_HI:`GPC_IC_DBN_LO]),
                .slow_tick           (slow_tick_q),
                .raw_q               (raw[g]),
                .filt_q              (filt[g]),
                .rise                (rise[g]),
                .fall                (fall[g])
            );
        end
    endgenerate

    // ****************************************************************
    // edge events gated by enables
    // ****************************************************************
    always @*
    begin
        ev_a = 16'h0000;
        ev_b = 16'h0000;
        for (ci = 0; ci < 16; ci = ci + 1)
        begin
            // an edge counts only while its own enable and an irq enable
            // are both set; otherwise it leaves no trace at all
            // gated edge events
            // route to irq a and b
            ev_a[ci] = ((rise[ci] & icfg_q[ci][`GPC_IC_REN]) | (fall[ci] & icfg_q[ci][`GPC_IC_FEN]))
                       & icfg_q[ci][`GPC_IC_IRQA];
            ev_b[ci] = ((rise[ci] & icfg_q[ci][`GPC_IC_REN]) | (fall[ci] & icfg_q[ci][`GPC_IC_FEN]))
                       & icfg_q[ci][`GPC_IC_IRQB];
        end
    end

    // ****************************************************************
    // apb slave and registers
    // ****************************************************************
    // sixteen consecutive words per group, one word per pin; a byte
    // offset that is not word aligned reaches no register
    wire       sel_o = aligned & (paddr[15:6] == oc_index[13:4]);
    wire       sel_i = aligned & (paddr[15:6] == ic_index[13:4]);
    wire       sel_f = aligned & (paddr[15:6] == fs_index[13:4]);
    wire [3:0] pin   = paddr[5:2];

    // ****************************************************************
    // register writes, edge flags and read data
    // ****************************************************************

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (i = 0; i < 16; i = i + 1)
            begin
                ocfg_q[i] <= `GPC_CFG_RESET;
                icfg_q[i] <= `GPC_CFG_RESET;
                fsel_q[i] <= `GPC_CFG_RESET;
            end
            rflag_q <= 16'h0000;
            fflag_q <= 16'h0000;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= acc;
            // misaligned or outside the three groups: error, write dropped
            pslverr <= acc & ~(sel_o | sel_i | sel_f);
            if (acc & pwrite)
            begin
                if (sel_o)
                    ocfg_q[pin] <= {1'b0, pwdata[6:0]};
                if (sel_i)
                    icfg_q[pin] <= pwdata[7:0];
                if (sel_f)
                    fsel_q[pin] <= pwdata[7:0];
            end
            for (i = 0; i < 16; i = i + 1)
            begin
                if (ev_a[i] | ev_b[i])
                begin
                    if (rise[i])
                        rflag_q[i] <= 1'b1;
                    if (fall[i])
                        fflag_q[i] <= 1'b1;
                end
                // a zero written to an edge enable clears its flag, unless
                // the same edge sets it again in this very cycle
                if (acc & pwrite & sel_i & (pin == i))
                begin
                    if (!pwdata[`GPC_IC_REN] && !((ev_a[i] | ev_b[i]) & rise[i]))
                        rflag_q[i] <= 1'b0;
                    if (!pwdata[`GPC_IC_FEN] && !((ev_a[i] | ev_b[i]) & fall[i]))
                        fflag_q[i] <= 1'b0;
                end
            end
            prdata <= 32'h0000_0000;
            if (acc & ~pwrite)
            begin
                if (sel_o)
                    prdata <= {24'h00_0000, ocfg_q[pin]};
                // reads show flags and status over the write-only fields
                // flags read on enable bits
                if (sel_i)
                    prdata <= {24'h00_0000, icfg_q[pin][7:6], rflag_q[pin], fflag_q[pin],
                               icfg_q[pin][3:2], filt[pin], raw[pin]};
                if (sel_f)
                    prdata <= {24'h00_0000, fsel_q[pin]};
            end
        end
    end

    // ****************************************************************
    // pin and core outputs
    // ****************************************************************
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out                <= 16'h0000;
            high_side_drive_enable <= 16'h0000;
            low_side_drive_enable  <= 16'h0000;
            pullup_enable          <= 16'h0000;
            pulldown_enable        <= 16'h0000;
            analog_switch_one      <= 16'h0000;
            analog_switch_two      <= 16'h0000;
            port_read              <= 16'h0000;
            function_select        <= 128'h0;
            pin_irq_a              <= 1'b0;
            pin_irq_b              <= 1'b0;
            wakeup                 <= 1'b0;
        end
        else
        begin
            // data and enables share one register stage, so they switch together
            for (oi = 0; oi < 16; oi = oi + 1)
            begin
                pin_out[oi]                <= port_data[oi] ^ ocfg_q[oi][`GPC_OC_OINV];
                high_side_drive_enable[oi] <= ocfg_q[oi][`GPC_OC_HSD];
                low_side_drive_enable[oi]  <= ocfg_q[oi][`GPC_OC_LSD];
                pullup_enable[oi]          <= ocfg_q[oi][`GPC_OC_PUP];
                pulldown_enable[oi]        <= ocfg_q[oi][`GPC_OC_PDN];
                analog_switch_one[oi]      <= ocfg_q[oi][`GPC_OC_AN1];
                analog_switch_two[oi]      <= ocfg_q[oi][`GPC_OC_AN2];
                function_select[oi*8 +: 8] <= fsel_q[oi];
            end
            port_read <= filt;
            pin_irq_a <= |ev_a;
            pin_irq_b <= |ev_b;
            wakeup    <= |(ev_a | ev_b);
        end
    end

endmodule

// ==== shared/gpc_defs.vh ====
/*
 * constants for the gpio pin configuration and edge interrupt block:
 * register offsets, field positions, reset values and debounce counts.
 * assumes an apb slave with 32-bit data, one register per aligned word.
 */
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH

// ****************************************************************
// register index of pin 0 in each group; byte address is four times it
// ****************************************************************
`define GPC_OUT_CFG_BASE   16'hA100
`define GPC_IN_CFG_BASE    16'hA110
`define GPC_FUNC_SEL_BASE  16'hA120
`define GPC_CFG_RESET      8'h00

// ****************************************************************
// output config fields
// ****************************************************************
`define GPC_OC_PDN         0
`define GPC_OC_PUP         1
`define GPC_OC_AN1         2
`define GPC_OC_AN2         3
`define GPC_OC_OINV        4
`define GPC_OC_LSD         5
`define GPC_OC_HSD         6

// ****************************************************************
// input config fields
// ****************************************************************
`define GPC_IC_DBN_LO      0
`define GPC_IC_DBN_HI      1
`define GPC_IC_RAW         0
`define GPC_IC_FILT        1
`define GPC_IC_IINV        2
`define GPC_IC_INPUT_BUFFER_ENABLE        3
`define GPC_IC_FEN         4
`define GPC_IC_REN         5
`define GPC_IC_IRQA        6
`define GPC_IC_IRQB        7

// ****************************************************************
// debounce counts in slow-oscillator/4 ticks
// ****************************************************************
`define GPC_DBN_TICKS_1    7'h04
`define GPC_DBN_TICKS_2    7'h10
`define GPC_DBN_TICKS_3    7'h40
`define GPC_SLOW_DIV       2'h3

`endif

// ==== verilog/gpc_pin_filter.v ====
/*
 * one pin's input path: sync, buffer enable, polarity, debounce and
 * edge detection. assumes slow_tick is a one-cycle pulse per slow
 * oscillator/4 period, produced in the pclk domain.
 */
`timescale 1ns/100ps
`include "gpc_defs.vh"

module gpc_pin_filter
(
    // clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // pin side
    input  wire       pin_in,
    input  wire       input_buffer_enable,
    input  wire       input_invert,
    input  wire [1:0] debounce_select,
    input  wire       slow_tick,
    // results
    output reg        raw_q,
    output reg        filt_q,
    output wire       rise,
    output wire       fall
);

    reg       sync1_q;
    reg       sync2_q;
    reg       prev_q;
    reg [6:0] cnt_q;
    reg [6:0] need;
    wire      buf_out;

    // disabled buffer reads low, no leakage path
    assign buf_out = sync2_q & input_buffer_enable;

    always @*
    begin
        case (debounce_select)
            2'd1:    need = `GPC_DBN_TICKS_1;
            2'd2:    need = `GPC_DBN_TICKS_2;
            2'd3:    need = `GPC_DBN_TICKS_3;
            default: need = 7'd0;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            raw_q   <= 1'b0;
            filt_q  <= 1'b0;
            prev_q  <= 1'b0;
            cnt_q   <= 7'd0;
        end
        else
        begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            raw_q   <= buf_out ^ input_invert;
            prev_q  <= filt_q;
            if (raw_q == filt_q)
                cnt_q <= 7'd0;
            else if (need == 7'd0)
                filt_q <= raw_q;
            else if (slow_tick)
            begin
                if (cnt_q + 7'd1 >= need)
                begin
                    filt_q <= raw_q;
                    cnt_q  <= 7'd0;
                end
                else
                    cnt_q <= cnt_q + 7'd1;
            end
        end
    end

    assign rise = filt_q & ~prev_q;
    assign fall = ~filt_q & prev_q;

endmodule

// ==== verification/gpc_gpio_cfg_props.sv ====
/* checker for gpc_gpio_cfg: apb handshake and causes of outputs.
   assumes it is bound to each gpc_gpio_cfg instance. */
`timescale 1ns/100ps
module gpc_gpio_cfg_props
(
    // apb
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [15:0]  paddr,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    // outputs
    input wire logic [15:0]  high_side_drive_enable,
    input wire logic [15:0]  low_side_drive_enable,
    input wire logic [127:0] function_select,
    input wire logic         pin_irq_a,
    input wire logic         pin_irq_b,
    input wire logic         wakeup
);
    wire acc  = psel && penable && !pready;
    // register index n at byte address 4*n, low 16 bits on paddr
    wire al   = paddr[1:0] == 2'b00;
    wire hit  = al && paddr[15:6] >= 10'h210 && paddr[15:6] <= 10'h212;
    wire w_fs = al && acc && pwrite && paddr[15:6] == 10'h212;
    wire w_oc = al && acc && pwrite && paddr[15:6] == 10'h210;
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    reset_drv_off_a: assert property ($rose(presetn) |-> (high_side_drive_enable | low_side_drive_enable) == 16'h0000)
        else $error("driver on right after reset");
    ready_time_a: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    map_ok_a: assert property (acc && hit |=> !pslverr)
        else $error("error on mapped register");
    unmap_err_a: assert property (acc && !hit |=> pslverr)
        else $error("no error on unmapped address");
    // register then output stage: a change shows two edges after the write
    fsel_write_a: assert property (!$stable(function_select) |-> $past(w_fs, 2))
        else $error("function select changed without write");
    drv_write_a: assert property (!$stable(low_side_drive_enable) |-> $past(w_oc, 2))
        else $error("drive enable changed without write");
    wake_or_a: assert property (wakeup == (pin_irq_a || pin_irq_b))
        else $error("wakeup differs from irq or");
endmodule
bind gpc_gpio_cfg gpc_gpio_cfg_props chk_u
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_side_drive_enable(high_side_drive_enable),
    .low_side_drive_enable(low_side_drive_enable), .function_select(function_select),
    .pin_irq_a(pin_irq_a), .pin_irq_b(pin_irq_b), .wakeup(wakeup)
);

// ==== verification/gpc_pin_model.sv ====
/* pin side: resolves each pin from drivers, pulls and an outside source.
   assumes pclk is the bench clock. */
`timescale 1ns/100ps
module gpc_pin_model
(
    // clock
    input  wire logic        pclk,
    // block side
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] high_side_drive_enable,
    input  wire logic [15:0] low_side_drive_enable,
    input  wire logic [15:0] pullup_enable,
    input  wire logic [15:0] pulldown_enable,
    // outside source
    input  wire logic [15:0] ext_drive,
    input  wire logic [15:0] ext_level,
    output logic      [15:0] pin_in
);
    // a floating pin wanders so no settled guess can pass
    logic [15:0] float_q = 16'h5a5a;
    always @(posedge pclk)
        float_q <= ~float_q;
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            if (high_side_drive_enable[i] && pin_out[i])
                pin_in[i] = 1'b1;
            else if (low_side_drive_enable[i] && !pin_out[i])
                pin_in[i] = 1'b0;
            else if (ext_drive[i])
                pin_in[i] = ext_level[i];
            else if (pullup_enable[i] || pulldown_enable[i])
                pin_in[i] = pullup_enable[i];
            else
                pin_in[i] = float_q[i];
        end
    end
endmodule

// ==== verification/gpc_gpio_cfg_test.sv ====
/* self-checking bench for gpc_gpio_cfg: apb master, pin model, expected
   values kept in arrays. assumes register index n at byte address 4*n on paddr. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("ERROR %0t got %h want %h", $time, g, e); end end
module gpc_gpio_cfg_test;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic         slow_osc_tick = 1'b0;
    logic [15:0]  paddr = 16'h0000;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic [15:0]  port_data = 16'h0000;
    logic [15:0]  ext_drive = 16'hffff;
    logic [15:0]  ext_level = 16'h0000;
    wire  [31:0]  prdata;
    wire          pready, pslverr, pin_irq_a, pin_irq_b, wakeup;
    wire  [15:0]  pin_in, pin_out, hs_en, ls_en, pu_en, pd_en, an1, an2, port_read;
    wire  [127:0] function_select;
    int           mismatches = 0;
    int           n_tests = 0;
    int           n_a = 0, n_b = 0, n_w = 0;
    logic [31:0]  seed = 32'd6;
    // ****************************************************************
    // clock, timebase, irq counters, instances
    // ****************************************************************
    initial
    begin
        forever #5 pclk = ~pclk;
    end
    // tick every second cycle keeps debounce waits short
    always @(posedge pclk)
    begin
        slow_osc_tick <= ~slow_osc_tick;
        n_a <= n_a + (pin_irq_a === 1'b1);
        n_b <= n_b + (pin_irq_b === 1'b1);
        n_w <= n_w + (wakeup === 1'b1);
    end
    gpc_gpio_cfg dut_u
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_osc_tick(slow_osc_tick), .pin_in(pin_in), .pin_out(pin_out),
        .high_side_drive_enable(hs_en), .low_side_drive_enable(ls_en), .pullup_enable(pu_en),
        .pulldown_enable(pd_en), .analog_switch_one(an1), .analog_switch_two(an2), .port_data(port_data),
        .port_read(port_read), .function_select(function_select), .pin_irq_a(pin_irq_a),
        .pin_irq_b(pin_irq_b), .wakeup(wakeup)
    );
    gpc_pin_model pins_u
    (
        .pclk(pclk), .pin_out(pin_out), .high_side_drive_enable(hs_en), .low_side_drive_enable(ls_en),
        .pullup_enable(pu_en), .pulldown_enable(pd_en), .ext_drive(ext_drive), .ext_level(ext_level),
        .pin_in(pin_in)
    );
    // ****************************************************************
    // tasks
    // ****************************************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic wait_c(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr8(input logic [15:0] a, input logic [7:0] v);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, 16'(a * 4), {24'h00_0000, v}, rd, er);
    endtask
    task automatic rd8(input logic [15:0] a, output logic [7:0] v);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, 16'(a * 4), 32'h0000_0000, rd, er);
        v = rd[7:0];
    endtask
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #400000;
        mismatches++;
        close_out();
    end
    // ****************************************************************
    // tests
    // ****************************************************************
    initial
    begin
        logic [31:0]  rd;
        logic         er;
        logic [7:0]   v, en;
        logic [7:0]   oc_m [16];
        logic [127:0] fs_v;
        logic [7:0]   t_oc [6] = '{8'h02, 8'h02, 8'h01, 8'h01, 8'h30, 8'h40};
        logic [7:0]   t_ic [6] = '{8'h00, 8'h08, 8'h08, 8'h0c, 8'h0c, 8'h0c};
        logic [7:0]   t_ex [6] = '{8'h00, 8'h0b, 8'h08, 8'h0f, 8'h0f, 8'h0c};
        int           ba, bb, bw, c, nd, lo, hi;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK(hs_en | ls_en | pu_en | pd_en | an1 | an2, 16'h0000)
        for (int i = 0; i < 48; i++)
        begin
            rd8(16'hA100 + 16'(i), v);
            `CHK(v, 8'h00)
        end
        $display("test reset done");
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            oc_m[i] = seed[7:0] & 8'h7f;
            fs_v[i*8 +: 8] = seed[15:8];
            wr8(16'hA100 + 16'(i), seed[7:0]);
            wr8(16'hA120 + 16'(i), seed[15:8]);
            rd8(16'hA100 + 16'(i), v);
            `CHK(v, oc_m[i])
        end
        port_data <= seed[31:16];
        wait_c(4);
        for (int i = 0; i < 16; i++)
        begin
            `CHK({hs_en[i], ls_en[i], an2[i], an1[i], pu_en[i], pd_en[i]}, {oc_m[i][6:5], oc_m[i][3:0]})
            `CHK(pin_out[i], port_data[i] ^ oc_m[i][4])
            wr8(16'hA100 + 16'(i), 8'h00);
        end
        rd8(16'hA12F, v);
        `CHK(v, fs_v[127:120])
        `CHK(function_select, fs_v)
        // index A130, the word just past the last group
        apb(1'b1, 16'h84c0, 32'h0000_00ff, rd, er);
        `CHK(er, 1'b1)
        apb(1'b0, 16'h84c0, 32'h0000_0000, rd, er);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        apb(1'b0, 16'h8401, 32'h0000_0000, rd, er);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        $display("test registers done");
        ext_drive[3] <= 1'b0;
        port_data[3] <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            wr8(16'hA103, t_oc[k]);
            wr8(16'hA113, t_ic[k]);
            wait_c(8);
            rd8(16'hA113, v);
            `CHK(v, t_ex[k])
            `CHK(port_read[3], t_ex[k][1])
        end
        wr8(16'hA103, 8'h00);
        ext_drive[3] <= 1'b1;
        $display("test pin path done");
        for (int r = 0; r < 3; r++)
        begin
            en = (r == 0) ? 8'h00 : (r == 1) ? 8'h40 : 8'h80;
            ext_level[9] <= 1'b0;
            wait_c(10);
            wr8(16'hA119, en | 8'h38);
            wait_c(10);
            ba = n_a;
            bb = n_b;
            bw = n_w;
            ext_level[9] <= 1'b1;
            wait_c(10);
            rd8(16'hA119, v);
            `CHK(v, en | 8'h0b | ((r != 0) ? 8'h20 : 8'h00))
            ext_level[9] <= 1'b0;
            wait_c(10);
            rd8(16'hA119, v);
            `CHK(v, en | 8'h08 | ((r != 0) ? 8'h30 : 8'h00))
            `CHK(n_a - ba, (r == 1) ? 2 : 0)
            `CHK(n_b - bb, (r == 2) ? 2 : 0)
            `CHK(n_w - bw, (r != 0) ? 2 : 0)
            wr8(16'hA119, en | 8'h08);
            ext_level[9] <= 1'b1;
            wait_c(10);
            rd8(16'hA119, v);
            `CHK(v, en | 8'h0b)
        end
        $display("test edges done");
        for (int d = 0; d < 4; d++)
        begin
            nd = (d == 0) ? 0 : (d == 1) ? 4 : (d == 2) ? 16 : 64;
            ext_level[9] <= 1'b0;
            wr8(16'hA119, 8'h08 | 8'(d));
            wait_c(700);
            ext_level[9] <= 1'b1;
            c = 0;
            while (port_read[9] !== 1'b1 && c < 1000)
            begin
                @(posedge pclk);
                c++;
            end
            lo = (nd == 0) ? 0 : (nd - 1) * 8;
            hi = nd * 8 + 12;
            `CHK(c >= lo && c <= hi, 1'b1)
        end
        ext_level[9] <= 1'b0;
        wait_c(40);
        rd8(16'hA119, v);
        `CHK(v, 8'h0a)
        $display("test debounce done");
        close_out();
    end
endmodule
